// *** hdl/homing_params.svh ***
// offsets, field positions and reset values of the homing sequencer
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH

// ------------------------------------------------------------
// object dictionary indices and subindices
// ------------------------------------------------------------
`define OD_ZERO_OFFSET  16'h607C
`define OD_METHOD       16'h6098
`define OD_SPEEDS       16'h6099
`define OD_ACCEL        16'h609A
`define OD_SUB_MAIN     8'h00
`define OD_SUB_SEARCH   8'h01
`define OD_SUB_APPROACH 8'h02

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_ZERO_OFFSET 32'h0
`define RST_METHOD      8'h14
`define SPEED_ENTRIES   8'h02
`define RST_SEARCH      32'h190
`define RST_APPROACH    32'h64
`define RST_ACCEL       32'h32
`define CURRENT_ZERO    32'h0

// ------------------------------------------------------------
// mode, method and word bit positions
// ------------------------------------------------------------
`define MODE_HOMING     8'h06
`define METHOD_CURRENT  8'h23
`define CW_START_BIT    4
`define SW_REACHED_BIT  10
`define SW_ATTAINED_BIT 12
`define SW_ERROR_BIT    13

`endif

// *** hdl/homing_pkg.sv ***
// types shared by the homing sequencer
package homing_pkg;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0001,
        ST_SEEK     = 4'b0010,
        ST_APPROACH = 4'b0100,
        ST_INDEX    = 4'b1000
    } seq_state_t;

    typedef enum logic [1:0] {
        REF_NONE  = 2'h0,
        REF_LOWER = 2'h1,
        REF_UPPER = 2'h2,
        REF_HOME  = 2'h3
    } ref_sel_t;

    // ------------------------------------------------------------
    // decoded method; directions are 1 for positive
    // ------------------------------------------------------------
    typedef struct packed {
        logic     valid;
        ref_sel_t ref_sel;
        logic     home_dir;
        logic     home_lvl;
        logic     dir_off;
        logic     dir_on;
        logic     use_index;
    } method_cfg_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        move_en;
        logic        dir_pos;
        logic        pos_mode;
        logic [31:0] speed;
        logic [31:0] accel;
    } motion_cmd_t;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] wdata;
    } od_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } od_rsp_t;

    typedef struct packed {
        logic lower_lim;
        logic upper_lim;
        logic home_sw;
        logic index_pulse;
        logic soft_en;
        logic soft_lo_hit;
        logic soft_hi_hit;
    } sense_t;

    typedef struct packed {
        seq_state_t  state;
        logic        dir_pos;
        logic        fast;
        logic        cw_start_q;
        logic        ref_q;
        logic        idx_q;
        logic        reached;
        logic        attained;
        logic        fault;
        method_cfg_t cfg;
        logic        load;
        logic [31:0] load_val;
        od_rsp_t     od;
        logic [31:0] zero_offset;
        logic [7:0]  method;
        logic [31:0] search_speed;
        logic [31:0] approach_speed;
        logic [31:0] accel;
    } seq_regs_t;

endpackage

// *** hdl/homing_sequencer.sv ***
// homing sequencer: reference search, status handshake, parameters
`timescale 1ns/1ns
`default_nettype none
`include "homing_params.svh"

// Function
// - signed zero offset, reset zero, loaded at home (method 35 loads 0)
// - methods 1-14, 17-30, 33, 34, 35 supported
// - 1/17: to lower limit, back off edge
// - method 1 adds index pulse; 17 homes at edge
// - 2/18 mirror using upper limit switch
// - 3,4,19,20: direction from positive home switch
// - 5,6,21,22: direction from negative home switch
// - 21-30 home at edge, index ignored
// - 7-14 continue to next index pulse
// - 7/23, 8/24 bottom edges, positive if inactive
// - 9/25, 10/26 top edges, always positive
// - 11/27, 12/28 top edges, negative if inactive
// - 13/29, 14/30 bottom edges, always negative
// - 33 negative, 34 positive to index
// - 35 zeroes position without motion
// - velocity to switches, position to index, soft limits
// - search 400, approach 100, acceleration 50
// - start bit 4 clears status 12, 10
// - home reached sets status 12 and 10
// - clearing bit 4 aborts: 10 set, 12 clear
// - clearing bit 4 resets status 12
module homing_sequencer (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // host command side
    input  wire logic [15:0]            ctrl_word,
    input  wire logic [7:0]             operating_mode_select,
    input  wire logic                   op_enabled,
    output logic [15:0]                 status_word,
    // object dictionary access
    input  wire homing_pkg::od_req_t    od_req,
    output homing_pkg::od_rsp_t         od_rsp,
    // switches and encoder
    input  wire homing_pkg::sense_t     sense,
    // drive side
    output homing_pkg::motion_cmd_t     motion,
    output logic                        pos_load,
    output logic [31:0]                 pos_load_value
);

    homing_pkg::seq_regs_t   st_r;
    homing_pkg::seq_regs_t   st_nxt;
    homing_pkg::method_cfg_t cfg_sel;
    logic                    ref_lvl;
    logic                    idx_rise;
    logic                    cw_start;
    logic                    start_ok;
    logic                    lim_hit;
    logic                    soft_hit;
    logic                    edge_seen;

    // ------------------------------------------------------------
    // method decode
    // ------------------------------------------------------------
    function automatic homing_pkg::method_cfg_t decode(
        input logic [7:0] m
    );
        homing_pkg::method_cfg_t c;
        logic [7:0]              b;
        c = '0;
        b = (m > 8'h10) ? 8'(m - 8'h10) : m;
        c.use_index = (m < 8'h0F);
        if ((m >= 8'h01 && m <= 8'h0E) || (m >= 8'h11 && m <= 8'h1E)) begin
            c.valid   = 1'b1;
            c.ref_sel = homing_pkg::REF_HOME;
            unique case (b)
                8'h01: begin
                    c.ref_sel = homing_pkg::REF_LOWER;
                    {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b1001;
                end
                8'h02: begin
                    c.ref_sel = homing_pkg::REF_UPPER;
                    {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b0010;
                end
                8'h03: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b0010;
                8'h04: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b1110;
                8'h05: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b1001;
                8'h06: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b0101;
                8'h07: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b0010;
                8'h08: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b1110;
                8'h09: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b0111;
                8'h0A: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b1011;
                8'h0B: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b1001;
                8'h0C: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b0101;
                8'h0D: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b1100;
                8'h0E: {c.home_dir, c.home_lvl, c.dir_off, c.dir_on} = 4'b0000;
                default: c.valid = 1'b0;
            endcase
        end else if (m == 8'h21 || m == 8'h22) begin
            c.valid     = 1'b1;
            c.use_index = 1'b1;
            c.dir_off   = m[0] ? 1'b0 : 1'b1;
            c.dir_on    = c.dir_off;
        end else if (m == `METHOD_CURRENT) begin
            c.valid     = 1'b1;
            c.use_index = 1'b0;
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // conditions
    // ------------------------------------------------------------
    always_comb begin
        cfg_sel  = decode(st_r.method);
        unique case (st_r.cfg.ref_sel)
            homing_pkg::REF_LOWER: ref_lvl = sense.lower_lim;
            homing_pkg::REF_UPPER: ref_lvl = sense.upper_lim;
            homing_pkg::REF_HOME:  ref_lvl = sense.home_sw;
            default:               ref_lvl = 1'b0;
        endcase
        cw_start  = ctrl_word[`CW_START_BIT];
        idx_rise  = sense.index_pulse && !st_r.idx_q;
        edge_seen = (ref_lvl != st_r.ref_q);
        // a hard limit that is not the reference turns the search round
        lim_hit = (!st_r.dir_pos && sense.lower_lim
                   && st_r.cfg.ref_sel != homing_pkg::REF_LOWER)
               || (st_r.dir_pos && sense.upper_lim
                   && st_r.cfg.ref_sel != homing_pkg::REF_UPPER);
        soft_hit = sense.soft_en
                && ((!st_r.dir_pos && sense.soft_lo_hit)
                    || (st_r.dir_pos && sense.soft_hi_hit));
        start_ok = cw_start && !st_r.cw_start_q && op_enabled
                && operating_mode_select == `MODE_HOMING;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt            = st_r;
        st_nxt.cw_start_q = cw_start;
        st_nxt.idx_q      = sense.index_pulse;
        st_nxt.load       = 1'b0;
        st_nxt.od.ack     = 1'b0;
        st_nxt.od.err     = 1'b0;

        unique case (st_r.state)
            homing_pkg::ST_IDLE: begin
                if (!cw_start) begin
                    st_nxt.attained = 1'b0;
                end
                if (start_ok && cfg_sel.valid) begin
                    st_nxt.cfg      = cfg_sel;
                    st_nxt.reached  = 1'b0;
                    st_nxt.attained = 1'b0;
                    st_nxt.fault    = 1'b0;
                    st_nxt.fast     = 1'b1;
                    st_nxt.ref_q    = 1'b0;
                    if (st_r.method == `METHOD_CURRENT) begin
                        st_nxt.load     = 1'b1;
                        st_nxt.load_val = `CURRENT_ZERO;
                        st_nxt.reached  = 1'b1;
                        st_nxt.attained = 1'b1;
                    end else if (cfg_sel.ref_sel == homing_pkg::REF_NONE) begin
                        st_nxt.dir_pos = cfg_sel.dir_off;
                        st_nxt.fast    = 1'b0;
                        st_nxt.state   = homing_pkg::ST_INDEX;
                    end else begin
                        unique case (cfg_sel.ref_sel)
                            homing_pkg::REF_LOWER: st_nxt.ref_q = sense.lower_lim;
                            homing_pkg::REF_UPPER: st_nxt.ref_q = sense.upper_lim;
                            default:               st_nxt.ref_q = sense.home_sw;
                        endcase
                        st_nxt.dir_pos = st_nxt.ref_q ? cfg_sel.dir_on
                                                      : cfg_sel.dir_off;
                        st_nxt.state   = homing_pkg::ST_SEEK;
                    end
                end
            end
            homing_pkg::ST_SEEK, homing_pkg::ST_APPROACH: begin
                st_nxt.ref_q = ref_lvl;
                if (edge_seen && st_r.dir_pos == st_r.cfg.home_dir
                        && ref_lvl == st_r.cfg.home_lvl) begin
                    if (st_r.cfg.use_index) begin
                        st_nxt.state = homing_pkg::ST_INDEX;
                        st_nxt.fast  = 1'b0;
                    end else begin
                        st_nxt.load     = 1'b1;
                        st_nxt.load_val = st_r.zero_offset;
                        st_nxt.reached  = 1'b1;
                        st_nxt.attained = 1'b1;
                        st_nxt.state    = homing_pkg::ST_IDLE;
                    end
                end else if ((edge_seen && st_r.dir_pos != st_r.cfg.home_dir
                        && ref_lvl != st_r.cfg.home_lvl) || lim_hit) begin
                    st_nxt.dir_pos = !st_r.dir_pos;
                    st_nxt.fast    = 1'b0;
                    st_nxt.state   = homing_pkg::ST_APPROACH;
                end
            end
            homing_pkg::ST_INDEX: begin
                if (idx_rise) begin
                    st_nxt.load     = 1'b1;
                    st_nxt.load_val = st_r.zero_offset;
                    st_nxt.reached  = 1'b1;
                    st_nxt.attained = 1'b1;
                    st_nxt.state    = homing_pkg::ST_IDLE;
                end else if ((!st_r.dir_pos && sense.lower_lim)
                        || (st_r.dir_pos && sense.upper_lim)) begin
                    st_nxt.fault   = 1'b1;
                    st_nxt.reached = 1'b1;
                    st_nxt.state   = homing_pkg::ST_IDLE;
                end
            end
            default: st_nxt.state = homing_pkg::ST_IDLE;
        endcase

        // soft limit ends the run as a fault
        if (st_r.state != homing_pkg::ST_IDLE && soft_hit) begin
            st_nxt.fault    = 1'b1;
            st_nxt.reached  = 1'b1;
            st_nxt.attained = 1'b0;
            st_nxt.load     = 1'b0;
            st_nxt.state    = homing_pkg::ST_IDLE;
        end
        // cancel wins over any progress of this cycle
        if (st_r.state != homing_pkg::ST_IDLE
                && (!cw_start || !op_enabled
                    || operating_mode_select != `MODE_HOMING)) begin
            st_nxt.reached  = 1'b1;
            st_nxt.attained = 1'b0;
            st_nxt.load     = 1'b0;
            st_nxt.state    = homing_pkg::ST_IDLE;
        end

        // ------------------------------------------------------------
        // object dictionary access
        // ------------------------------------------------------------
        if (od_req.req) begin
            st_nxt.od.ack   = 1'b1;
            st_nxt.od.rdata = '0;
            unique case ({od_req.index, od_req.sub})
                {`OD_ZERO_OFFSET, `OD_SUB_MAIN}: begin
                    st_nxt.od.rdata = st_r.zero_offset;
                    if (od_req.wr) st_nxt.zero_offset = od_req.wdata;
                end
                {`OD_METHOD, `OD_SUB_MAIN}: begin
                    st_nxt.od.rdata = {24'h0, st_r.method};
                    if (od_req.wr) st_nxt.method = od_req.wdata[7:0];
                end
                {`OD_SPEEDS, `OD_SUB_MAIN}: begin
                    st_nxt.od.rdata = {24'h0, `SPEED_ENTRIES};
                    st_nxt.od.err   = od_req.wr;
                end
                {`OD_SPEEDS, `OD_SUB_SEARCH}: begin
                    st_nxt.od.rdata = st_r.search_speed;
                    if (od_req.wr) st_nxt.search_speed = od_req.wdata;
                end
                {`OD_SPEEDS, `OD_SUB_APPROACH}: begin
                    st_nxt.od.rdata = st_r.approach_speed;
                    if (od_req.wr) st_nxt.approach_speed = od_req.wdata;
                end
                {`OD_ACCEL, `OD_SUB_MAIN}: begin
                    st_nxt.od.rdata = st_r.accel;
                    if (od_req.wr) st_nxt.accel = od_req.wdata;
                end
                default: st_nxt.od.err = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r                <= '0;
            st_r.state          <= homing_pkg::ST_IDLE;
            st_r.zero_offset    <= `RST_ZERO_OFFSET;
            st_r.method         <= `RST_METHOD;
            st_r.search_speed   <= `RST_SEARCH;
            st_r.approach_speed <= `RST_APPROACH;
            st_r.accel          <= `RST_ACCEL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        status_word                   = '0;
        status_word[`SW_REACHED_BIT]  = st_r.reached;
        status_word[`SW_ATTAINED_BIT] = st_r.attained;
        status_word[`SW_ERROR_BIT]    = st_r.fault;
        motion.move_en  = (st_r.state != homing_pkg::ST_IDLE);
        motion.dir_pos  = st_r.dir_pos;
        motion.pos_mode = (st_r.state == homing_pkg::ST_INDEX);
        motion.speed    = st_r.fast ? st_r.search_speed
                                    : st_r.approach_speed;
        motion.accel    = st_r.accel;
    end

    assign od_rsp         = st_r.od;
    assign pos_load       = st_r.load;
    assign pos_load_value = st_r.load_val;

endmodule
`default_nettype wire

// *** dv/homing_sequencer_properties.sv ***
// port assertions of the homing sequencer
`timescale 1ns/1ns
`default_nettype none
module homing_sequencer_properties (
    // clock and reset
    input wire logic                    sys_clk,
    input wire logic                    rst,
    // host side
    input wire logic [15:0]             ctrl_word,
    input wire logic [7:0]              operating_mode_select,
    input wire logic                    op_enabled,
    input wire logic [15:0]             status_word,
    input wire homing_pkg::od_req_t     od_req,
    input wire homing_pkg::od_rsp_t     od_rsp,
    // drive side
    input wire homing_pkg::sense_t      sense,
    input wire homing_pkg::motion_cmd_t motion,
    input wire logic                    pos_load,
    input wire logic [31:0]             pos_load_value
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_go;
        $rose(motion.move_en);
    endsequence
    sequence s_home;
        pos_load ##1 !pos_load;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_go_clear;
        s_go |-> !status_word[12] && !status_word[10];
    endproperty
    property p_go_gate;
        s_go |-> $past(op_enabled) && $past(operating_mode_select) == 8'h06;
    endproperty
    property p_done;
        pos_load |-> status_word[12] && status_word[10] && !motion.move_en;
    endproperty
    property p_pulse;
        pos_load |-> s_home;
    endproperty
    property p_abort;
        motion.move_en && !ctrl_word[4]
            |=> !motion.move_en && status_word[10] && !status_word[12] && !pos_load;
    endproperty
    property p_rearm;
        status_word[12] && !ctrl_word[4] && !motion.move_en |=> !status_word[12];
    endproperty
    property p_soft;
        motion.move_en && sense.soft_en
            && (motion.dir_pos ? sense.soft_hi_hit : sense.soft_lo_hit)
            |=> !motion.move_en && status_word[10];
    endproperty
    property p_ack;
        od_req.req |=> od_rsp.ack;
    endproperty
    a_go_clear: assert property (p_go_clear) else $error("start left status set");
    a_go_gate: assert property (p_go_gate) else $error("run without homing mode");
    a_done: assert property (p_done) else $error("home without status");
    a_pulse: assert property (p_pulse) else $error("load pulse too long");
    a_abort: assert property (p_abort) else $error("cancel not honoured");
    a_rearm: assert property (p_rearm) else $error("attained not cleared");
    a_soft: assert property (p_soft) else $error("soft limit passed");
    a_ack: assert property (p_ack) else $error("access not answered");
endmodule

bind homing_sequencer homing_sequencer_properties i_homing_sequencer_properties (
    .sys_clk(sys_clk), .rst(rst), .ctrl_word(ctrl_word),
    .operating_mode_select(operating_mode_select), .op_enabled(op_enabled),
    .status_word(status_word), .od_req(od_req), .od_rsp(od_rsp), .sense(sense),
    .motion(motion), .pos_load(pos_load), .pos_load_value(pos_load_value)
);
`default_nettype wire

// *** dv/host_model.sv ***
// host controller model: command word, mode and dictionary access
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // clock
    input wire logic                  sys_clk,
    // command side
    output logic [15:0]               ctrl_word,
    output logic [7:0]                operating_mode_select,
    output logic                      op_enabled,
    // dictionary access
    output homing_pkg::od_req_t       od_req,
    input wire homing_pkg::od_rsp_t   od_rsp
);
    initial begin
        ctrl_word = 16'h0000;
        operating_mode_select = 8'h06;
        op_enabled = 1'b1;
        od_req = '0;
    end
    // one access, answer taken the cycle after
    task automatic od_rw(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                         input logic [31:0] wd, output logic [31:0] rd, output logic er);
        od_req = '{req: 1'b1, wr: wr, index: idx, sub: sub, wdata: wd};
        @(posedge sys_clk);
        #1;
        od_req = '{req: 1'b0, wr: ~wr, index: ~idx, sub: ~sub, wdata: ~wd};
        // data without an acknowledge reads back inverted and so mismatches
        rd = od_rsp.ack ? od_rsp.rdata : ~od_rsp.rdata;
        er = od_rsp.err;
        // one idle edge so the next access never reassigns the strobe at once
        @(posedge sys_clk);
        #1;
    endtask
    task automatic set_start(input logic on);
        ctrl_word[4] = on;
    endtask
endmodule
`default_nettype wire

// *** dv/homing_sequencer_bench.sv ***
// self-checking bench of the homing sequencer
`timescale 1ns/1ns
`default_nettype none
`include "homing_params.svh"
module homing_sequencer_bench;
    localparam logic [31:0] OFFS = 32'hFFFFFF9C;
    logic                    sys_clk, rst, op_enabled, pos_load, er;
    logic [15:0]             ctrl_word, status_word;
    logic [7:0]              operating_mode_select;
    logic [31:0]             pos_load_value, rd;
    homing_pkg::od_req_t     od_req;
    homing_pkg::od_rsp_t     od_rsp;
    homing_pkg::sense_t      sense;
    homing_pkg::motion_cmd_t motion;
    int                      fail_count, n_tests;
    logic [15:0] idx_t [6] = '{`OD_ZERO_OFFSET, `OD_METHOD, `OD_SPEEDS, `OD_SPEEDS,
                               `OD_SPEEDS, `OD_ACCEL};
    logic [7:0]  sub_t [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
    logic [31:0] rst_t [6] = '{32'h0, 32'h14, 32'h2, 32'h190, 32'h64, 32'h32};
    logic [15:0] dir_off = 16'h079C;
    logic [15:0] dir_on = 16'h1E60;

    homing_sequencer i_homing_sequencer (.sys_clk(sys_clk), .rst(rst),
        .ctrl_word(ctrl_word), .operating_mode_select(operating_mode_select),
        .op_enabled(op_enabled), .status_word(status_word), .od_req(od_req),
        .od_rsp(od_rsp), .sense(sense), .motion(motion), .pos_load(pos_load),
        .pos_load_value(pos_load_value));
    host_model i_host_model (.sys_clk(sys_clk), .ctrl_word(ctrl_word),
        .operating_mode_select(operating_mode_select), .op_enabled(op_enabled),
        .od_req(od_req), .od_rsp(od_rsp));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd);
        i_host_model.od_rw(wr, idx, sub, wd, rd, er);
    endtask
    task automatic go(input logic [7:0] m);
        od(1'b1, `OD_METHOD, `OD_SUB_MAIN, {24'h0, m});
        i_host_model.set_start(1'b1);
        tick();
    endtask
    task automatic stop();
        i_host_model.set_start(1'b0);
        tick(2);
    endtask
    // first leg toward sel, reversal at its rise, home at its fall, or with idx at the next index pulse
    task automatic run_edge(input logic [7:0] m, input int sel, input logic d,
                            input logic idx);
        go(m);
        chk(status_word, 32'h0);
        chk(motion.dir_pos, d);
        chk(motion.pos_mode, 1'b0);
        chk(motion.speed, `RST_SEARCH);
        chk(motion.accel, `RST_ACCEL);
        sense[sel] = 1'b1;
        tick();
        chk(motion.dir_pos, !d);
        chk(motion.speed, `RST_APPROACH);
        sense[sel] = 1'b0;
        tick();
        if (idx) begin
            chk(pos_load, 1'b0);
            chk(motion.pos_mode, 1'b1);
            sense.index_pulse = 1'b1;
            tick();
            sense.index_pulse = 1'b0;
        end
        chk(pos_load, 1'b1);
        chk(pos_load_value, OFFS);
        chk(status_word, 32'h1400);
        stop();
        chk(status_word, 32'h0400);
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #(40 * 20000);
        fail_count++;
        end_of_test();
    end
    initial begin
        fail_count = 0;
        n_tests = 0;
        rst = 1'b1;
        sense = '0;
        tick(2);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            od(1'b0, idx_t[i], sub_t[i], 32'h0);
            chk(rd, rst_t[i]);
        end
        od(1'b1, `OD_SPEEDS, `OD_SUB_MAIN, 32'h7);
        chk(er, 1'b1);
        od(1'b0, 16'h6060, 8'h00, 32'h0);
        chk(er, 1'b1);
        od(1'b1, `OD_ZERO_OFFSET, `OD_SUB_MAIN, OFFS);
        od(1'b0, `OD_ZERO_OFFSET, `OD_SUB_MAIN, 32'h0);
        chk(rd, OFFS);
        for (int m = 1; m < 31; m++) begin
            for (int s = 0; s < 2; s++) begin
                if (m != 15 && m != 16 && !(s == 1 && (m % 16) < 3)) begin
                    sense.home_sw = s[0];
                    go(8'(m));
                    chk(motion.move_en, 1'b1);
                    chk(motion.dir_pos, s ? dir_on[m % 16] : dir_off[m % 16]);
                    stop();
                end
            end
        end
        sense = '0;
        run_edge(8'h11, 6, 1'b0, 1'b0);
        run_edge(8'h01, 6, 1'b0, 1'b1);
        run_edge(8'h12, 5, 1'b1, 1'b0);
        run_edge(8'h02, 5, 1'b1, 1'b1);
        run_edge(8'h13, 4, 1'b1, 1'b0);
        run_edge(8'h15, 4, 1'b0, 1'b0);
        run_edge(8'h17, 4, 1'b1, 1'b0);
        run_edge(8'h07, 4, 1'b1, 1'b1);
        for (int k = 0; k < 2; k++) begin
            go(8'(33 + k));
            chk(motion.dir_pos, k[0]);
            chk(motion.pos_mode, 1'b1);
            sense.index_pulse = 1'b1;
            tick();
            sense.index_pulse = 1'b0;
            chk(pos_load, 1'b1);
            stop();
        end
        go(8'h23);
        chk(motion.move_en, 1'b0);
        chk(pos_load, 1'b1);
        chk(pos_load_value, 32'h0);
        stop();
        go(8'h11);
        tick(3);
        stop();
        chk(motion.move_en, 1'b0);
        chk(status_word, 32'h0400);
        go(8'h0F);
        chk(motion.move_en, 1'b0);
        chk(status_word, 32'h0400);
        stop();
        i_host_model.operating_mode_select = 8'h01;
        go(8'h11);
        chk(motion.move_en, 1'b0);
        stop();
        i_host_model.operating_mode_select = 8'h06;
        sense.soft_en = 1'b1;
        go(8'h11);
        sense.soft_lo_hit = 1'b1;
        tick();
        chk(motion.move_en, 1'b0);
        chk(status_word, 32'h2400);
        stop();
        end_of_test();
    end
endmodule
`default_nettype wire
